// *** rtl/bit_basic_timer.sv ***
// Summary of operation
// - Hold count when run is 0, count when 1.
// - Count advances one per prescaled clock tick.
// - Overflow is the 0xFF to 0x00 rollover.
// - Overflow sets sticky flag; software alone clears.
// - No reload; counting continues from zero.
// - Enabled overflow requests interrupt at vector 8.
// - Counts in normal, slow and green modes.
// - Green overflow sets flag and wakes system.
// - Rate field divides instruction clock 256 to 2.
// - Rate field bits 6:4; bits 3:0 unimplemented.
// - Run enable is mode bit 7.
// - Count register 8-bit, read/write, resets zero.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "bit_params.svh"

module bit_basic_timer
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       cpuTick,
  input  wire logic [7:0] address,
  input  wire logic [7:0] writeData,
  input  wire logic       writeStrobe,
  input  wire logic       readStrobe,
  output logic      [7:0] readData,
  output logic            irq,
  output logic      [7:0] irqVector,
  output logic            wakeUp,
  output logic      [1:0] powerMode
);

  logic [7:0]           modeReg_r;
  logic [7:0]           count_r;
  logic [7:0]           count_nxt;
  logic [7:0]           prescale_r;
  logic [7:0]           prescale_nxt;
  logic [1:0]           status_r;
  logic [1:0]           status_nxt;
  logic [1:0]           irqEnable_r;
  logic [1:0]           irqEnable_nxt;
  logic [7:0]           readData_r;
  logic [7:0]           irqVector_r;
  logic [7:0]           readMux;
  logic                 irq_r;
  logic                 wakeUp_r;
  bit_pkg::bit_power_t  power_r;
  bit_pkg::bit_power_t  power_nxt;
  bit_pkg::bit_power_t  prevPower_r;
  bit_pkg::bit_wake_t   wake_r;
  bit_pkg::bit_wake_t   wake_nxt;

  wire        runEnable   = modeReg_r[`BIT_MODE_RUN];
  wire [2:0]  prescaleSel = modeReg_r[`BIT_MODE_RATE_HI:`BIT_MODE_RATE_LO];
  // Divide by 2^(8-sel): terminal value is divisor minus one
  wire [7:0]  divLast     = `BIT_DIV_MAX >> prescaleSel;
  wire        selMode     = address == `BIT_ADDR_MODE;
  wire        selCount    = address == `BIT_ADDR_COUNT;
  wire        selStat     = address == `BIT_ADDR_IRQ_STAT;
  wire        selEn       = address == `BIT_ADDR_IRQ_EN;
  wire        selClr      = address == `BIT_ADDR_IRQ_CLR;
  wire        selPower    = address == `BIT_ADDR_POWER;
  wire        wrMode      = writeStrobe && selMode;
  wire        wrEnable    = writeStrobe && selEn;
  wire        wrPower     = writeStrobe && selPower;
  wire [1:0]  powerCode   = writeData[`BIT_PWR_HI:`BIT_PWR_LO];
  // Code 10 names no mode and is ignored
  wire        powerSleep  = powerCode == bit_pkg::BIT_PWR_GREEN;
  wire        powerAwake  = (powerCode == bit_pkg::BIT_PWR_NORMAL) ||
                            (powerCode == bit_pkg::BIT_PWR_SLOW);
  wire        enterGreen  = wrPower && powerSleep && (wake_r == bit_pkg::BIT_WK_IDLE);
  wire        wrCount     = writeStrobe && selCount;
  wire        wrClr       = writeStrobe && selClr;
  // Terminal test also catches a count left above a smaller divisor
  wire        preWrap     = prescale_r >= divLast;
  wire        timerTick   = runEnable && cpuTick && preWrap;
  wire        overflow    = timerTick && !wrCount && (count_r == `BIT_COUNT_FULL);
  wire        inGreen     = power_r == bit_pkg::BIT_PWR_GREEN;
  wire        greenWake   = overflow && inGreen;
  wire [1:0]  clrMask     = wrClr ? writeData[1:0] : 2'b00;
  wire [1:0]  setMask     = {greenWake, overflow};

  // Prescaler, cleared while stopped
  always_comb
  begin
    prescale_nxt = prescale_r;
    if (!runEnable)
    begin
      prescale_nxt = `BIT_ZERO8;
    end
    else if (cpuTick)
    begin
      prescale_nxt = preWrap ? `BIT_ZERO8 : prescale_r + `BIT_DIV_ONE;
    end
  end

  // Count: software write wins, otherwise free-running wrap
  always_comb
  begin
    count_nxt = count_r;
    if (wrCount)
    begin
      count_nxt = writeData;
    end
    else if (timerTick)
    begin
      count_nxt = count_r + `BIT_COUNT_ONE;
    end
  end

  // Sticky flags: set beats clear
  assign status_nxt = (status_r & ~clrMask) | setMask;
  assign irqEnable_nxt = wrEnable ? writeData[1:0] : irqEnable_r;

  // Power mode tracking with green wake-up
  always_comb
  begin
    power_nxt = power_r;
    wake_nxt  = wake_r;
    case (wake_r)
      bit_pkg::BIT_WK_IDLE:
      begin
        if (wrPower && (powerAwake || powerSleep))
        begin
          power_nxt = bit_pkg::bit_power_t'(powerCode);
          if (powerSleep)
          begin
            wake_nxt = bit_pkg::BIT_WK_ASLP;
          end
        end
      end
      bit_pkg::BIT_WK_ASLP:
      begin
        if (greenWake)
        begin
          wake_nxt = bit_pkg::BIT_WK_WAKE;
        end
      end
      bit_pkg::BIT_WK_WAKE:
      begin
        power_nxt = prevPower_r;
        wake_nxt  = bit_pkg::BIT_WK_IDLE;
      end
      default:
      begin
        wake_nxt = bit_pkg::BIT_WK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      prevPower_r <= bit_pkg::BIT_PWR_NORMAL;
    end
    else if (enterGreen)
    begin
      prevPower_r <= power_r;
    end
  end

  // Read multiplexer
  assign readMux = selMode  ? (modeReg_r & `BIT_MODE_MASK) :
                   selCount ? count_r :
                   selStat  ? {6'h00, status_r} :
                   selEn    ? {6'h00, irqEnable_r} :
                   selPower ? {6'h00, power_r} :
                   `BIT_ZERO8;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      modeReg_r <= `BIT_MODE_RST;
    end
    else if (wrMode)
    begin
      modeReg_r <= writeData & `BIT_MODE_MASK;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      count_r <= `BIT_COUNT_RST;
    end
    else
    begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      prescale_r <= `BIT_ZERO8;
    end
    else
    begin
      prescale_r <= prescale_nxt;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      status_r <= 2'h0;
    end
    else
    begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      irqEnable_r <= 2'h0;
    end
    else if (wrEnable)
    begin
      irqEnable_r <= writeData[1:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      power_r <= bit_pkg::BIT_PWR_NORMAL;
      wake_r  <= bit_pkg::BIT_WK_IDLE;
    end
    else
    begin
      power_r <= power_nxt;
      wake_r  <= wake_nxt;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      readData_r <= `BIT_ZERO8;
    end
    else
    begin
      readData_r <= readStrobe ? readMux : `BIT_ZERO8;
    end
  end

  // Level follows the next status and enable, so both change irq on one edge
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      irq_r <= 1'h0;
    end
    else
    begin
      irq_r <= |(status_nxt & irqEnable_nxt);
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wakeUp_r <= 1'h0;
    end
    else
    begin
      wakeUp_r <= greenWake;
    end
  end

  // Vector held in a flop so every output is registered
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      irqVector_r <= `BIT_IRQ_VECTOR;
    end
  end

  assign readData  = readData_r;
  assign irq       = irq_r;
  assign irqVector = irqVector_r;
  assign wakeUp    = wakeUp_r;
  assign powerMode = power_r;

endmodule // bit_basic_timer

`default_nettype wire

// *** rtl/bit_params.svh ***
`ifndef BIT_PARAMS_SVH
`define BIT_PARAMS_SVH

// Register addresses on the strobed port
`define BIT_ADDR_MODE      8'hD8
`define BIT_ADDR_COUNT     8'hD9
`define BIT_ADDR_IRQ_STAT  8'hDA
`define BIT_ADDR_IRQ_EN    8'hDB
`define BIT_ADDR_IRQ_CLR   8'hDC
`define BIT_ADDR_POWER     8'hDD

// Mode register fields
`define BIT_MODE_RUN       7
`define BIT_MODE_RATE_HI   6
`define BIT_MODE_RATE_LO   4
`define BIT_MODE_MASK      8'hF0

// Status, enable and clear layout
`define BIT_IRQ_OVF        0
`define BIT_IRQ_WAKE       1
`define BIT_IRQ_MASK       8'h03

// Power register fields
`define BIT_PWR_HI         1
`define BIT_PWR_LO         0

// Reset values
`define BIT_MODE_RST       8'h00
`define BIT_COUNT_RST      8'h00
`define BIT_ZERO8          8'h00

// Counter limits and interrupt vector
`define BIT_COUNT_FULL     8'hFF
`define BIT_COUNT_ONE      8'h01
`define BIT_DIV_ONE        8'h01
`define BIT_DIV_MAX        8'hFF
`define BIT_IRQ_VECTOR     8'h08

`endif

// *** rtl/bit_pkg.sv ***
`default_nettype none

package bit_pkg;

  // Power modes, Gray coded
  typedef enum logic [1:0] {
    BIT_PWR_NORMAL = 2'b00,
    BIT_PWR_SLOW   = 2'b01,
    BIT_PWR_GREEN  = 2'b11
  } bit_power_t;

  // Wake state machine, Gray coded
  typedef enum logic [1:0] {
    BIT_WK_IDLE  = 2'b00,
    BIT_WK_ASLP  = 2'b01,
    BIT_WK_WAKE  = 2'b11
  } bit_wake_t;

endpackage

`default_nettype wire

// *** testbench/bit_basic_timer_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module bit_basic_timer_tb;
  logic       clock = 1'h0, reset = 1'h1, cpuTick = 1'h0, sawWake = 1'h0;
  logic       writeStrobe = 1'h0, readStrobe = 1'h0, irq, wakeUp;
  logic [7:0] address = 8'h00, writeData = 8'h00, readData, irqVector;
  logic [1:0] powerMode;
  int         n_fail = 0, n_compared = 0, cyc = 0, r;
  always #4 clock = ~clock;
  bit_basic_timer dut (.clock(clock), .reset(reset), .cpuTick(cpuTick), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .irq(irq), .irqVector(irqVector), .wakeUp(wakeUp),
    .powerMode(powerMode));
  task conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    sawWake <= sawWake | wakeUp;
    if (cyc == 6000)
    begin
      n_fail++;
      conclude();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'h1;
    @(posedge clock);
    writeStrobe <= 1'h0;
    @(posedge clock);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    address <= a;
    readStrobe <= 1'h1;
    @(posedge clock);
    readStrobe <= 1'h0;
    @(negedge clock);
    chk(readData, e);
    @(posedge clock);
  endtask
  task tk(input int n);
    repeat (n)
    begin
      cpuTick <= 1'h1;
      @(posedge clock);
      cpuTick <= 1'h0;
      @(posedge clock);
    end
  endtask
  task fl(input logic [7:0] e);
    @(negedge clock);
    chk({7'h00, irq}, e);
    @(posedge clock);
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    rd(8'hD8, 8'h00);
    rd(8'hD9, 8'h00);
    rd(8'hE0, 8'h00);
    wr(8'hD8, 8'h7F);
    rd(8'hD8, 8'h70);
    wr(8'hD9, 8'h10);
    tk(4);
    rd(8'hD9, 8'h10);
    wr(8'hD8, 8'hF0);
    tk(1);
    wr(8'hD8, 8'h70);
    wr(8'hD8, 8'hF0);
    tk(1);
    rd(8'hD9, 8'h10);
    tk(1);
    rd(8'hD9, 8'h11);
    for (r = 0; r < 8; r++)
    begin
      wr(8'hD8, {1'h0, r[2:0], 4'h0});
      wr(8'hD9, 8'h20);
      wr(8'hD8, {1'h1, r[2:0], 4'h0});
      tk((256 >> r) - 1);
      rd(8'hD9, 8'h20);
      tk(1);
      rd(8'hD9, 8'h21);
    end
    wr(8'hDB, 8'h01);
    wr(8'hD9, 8'hFF);
    tk(2);
    rd(8'hD9, 8'h00);
    fl(8'h01);
    chk(irqVector, 8'h08);
    tk(2);
    rd(8'hD9, 8'h01);
    rd(8'hDA, 8'h01);
    chk({7'h00, sawWake}, 8'h00);
    wr(8'hDB, 8'h00);
    fl(8'h00);
    wr(8'hDB, 8'h01);
    wr(8'hDC, 8'h01);
    rd(8'hDA, 8'h00);
    fl(8'h00);
    wr(8'hDD, 8'h03);
    wr(8'hD9, 8'hFF);
    tk(2);
    rd(8'hD9, 8'h00);
    rd(8'hDA, 8'h03);
    chk({7'h00, sawWake}, 8'h01);
    chk({6'h00, powerMode}, 8'h00);
    wr(8'hDD, 8'h01);
    tk(2);
    rd(8'hD9, 8'h01);
    wr(8'hDD, 8'h03);
    wr(8'hD9, 8'hFF);
    tk(2);
    rd(8'hD9, 8'h00);
    chk({6'h00, powerMode}, 8'h01);
    wr(8'hD9, 8'h5A);
    reset <= 1'h1;
    repeat (2) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    rd(8'hD9, 8'h00);
    rd(8'hD8, 8'h00);
    rd(8'hDA, 8'h00);
    fl(8'h00);
    chk({6'h00, powerMode}, 8'h00);
    conclude();
  end
endmodule // bit_basic_timer_tb
`default_nettype wire

// *** testbench/bit_timer_chk_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module bit_timer_chk
(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       cpuTick,
  input wire logic [7:0] address,
  input wire logic [7:0] writeData,
  input wire logic       writeStrobe,
  input wire logic       readStrobe,
  input wire logic [7:0] readData,
  input wire logic       irq,
  input wire logic [7:0] irqVector,
  input wire logic       wakeUp,
  input wire logic [1:0] powerMode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence sPwrSlow;
    writeStrobe && address == 8'hDD && writeData[1:0] == 2'b01 && powerMode != 2'b11;
  endsequence
  sequence sWakeBack;
    ##[1:3] powerMode != 2'b11;
  endsequence
  vector_fixed_a: assert property (irqVector == 8'h08)
    else $error("vector changed");
  read_idle_a: assert property (!$past(readStrobe) |-> readData == 8'h00)
    else $error("read data outside slot");
  irq_mask_a: assert property (writeStrobe && address == 8'hDB && writeData == 8'h00 |=> !irq)
    else $error("masked irq stays high");
  wake_green_a: assert property (wakeUp |-> $past(powerMode) == 2'b11)
    else $error("wake outside green");
  wake_pulse_a: assert property (wakeUp |=> !wakeUp)
    else $error("wake too long");
  wake_back_a: assert property (wakeUp |-> sWakeBack)
    else $error("no return from green");
  reset_vals_a: assert property ($fell(reset) |-> readData == 8'h00 && !irq && powerMode == 2'b00)
    else $error("bad reset values");
  mode_low_a: assert property (readStrobe && address == 8'hD8 |=> readData[3:0] == 4'h0)
    else $error("mode low bits not zero");
  pwr_slow_a: assert property (sPwrSlow |=> powerMode == 2'b01)
    else $error("slow mode not taken");
  irq_hold_a: assert property (irq && !(writeStrobe && address inside {8'hDB, 8'hDC})
    |=> irq) else $error("irq dropped without software");
endmodule // bit_timer_chk
bind bit_basic_timer bit_timer_chk u_chk (.clock(clock), .reset(reset), .cpuTick(cpuTick),
  .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
  .readStrobe(readStrobe), .readData(readData), .irq(irq), .irqVector(irqVector),
  .wakeUp(wakeUp), .powerMode(powerMode));
`default_nettype wire
